// ### core/burst_sram_cycle_control.sv
// Cycle control, burst counter, byte-lane writes and data drivers of a 128K x 18 burst SRAM.
//
// Behaviour
// [RQ1] Controller strobe with primary select high, or failed selects, deselects; data high-Z.
// [RQ2] All selects active with processor strobe low loads address and starts a read.
// [RQ3] Controller strobe, processor strobe high, write term low: load address, capture data.
// [RQ4] No new strobe, advance low, write term high: read from next burst address.
// [RQ5] No new strobe, advance low, write term low: step address and capture data.
// [RQ6] No new strobe, advance high, write term high: reread current burst address.
// [RQ7] No new strobe, advance high, write term low: write current address, counter held.
// [RQ8] Advance held high is a wait cycle that holds the burst address.
// [RQ9] Write term is low on global write, or gate low with a byte enable low.
// [RQ10] Low enable covers low byte and low parity; high enable the high pair.
// [RQ11] All inputs sampled on rising edge; output enable gates drivers asynchronously.
// [RQ12] Controller raises output enable early before a write that follows a read.
// [RQ13] Data and parity drivers stay off throughout power-up.
// [RQ14] Processor strobe with chip selected always begins a read, ignoring write inputs; the core deselects instead while snooze is active.
// [RQ15] Controller writes after a processor strobe in the following wait cycle.
// [RQ16] Order pin low gives linear bursts; high or open gives interleaved bursts.
// [RQ17] Burst addresses change only the two lowest address bits.
// [RQ18] Two-bit counter wraps within an aligned group of four words.
`timescale 1ns/1ns
module burst_sram_cycle_control (
  input  wire logic                              core_clk_i,
  input  wire logic                              resetn_i,
  input  wire logic [sram_cycle_pkg::ADDR_W-1:0] address_i,
  input  wire logic                              primary_select_n_i,
  input  wire logic                              second_select_n_i,
  input  wire logic                              third_select_high_i,
  input  wire logic                              processor_addr_strobe_n_i,
  input  wire logic                              controller_addr_strobe_n_i,
  input  wire logic                              burst_step_n_i,
  input  wire logic                              byte_write_gate_n_i,
  input  wire logic                              all_bytes_store_n_i,
  input  wire logic                              low_byte_store_n_i,
  input  wire logic                              high_byte_store_n_i,
  input  wire logic                              output_enable_n_i,
  input  wire logic                              burst_order_i,
  input  wire logic                              snooze_request_i,
  input  wire logic [15:0]                       dq_i,
  output logic [15:0]                            dq_o,
  output logic [15:0]                            dq_oe_o,
  input  wire logic                              low_parity_pin_i,
  output logic                                   low_parity_pin_o,
  output logic                                   low_parity_pin_oe_o,
  input  wire logic                              high_parity_pin_i,
  output logic                                   high_parity_pin_o,
  output logic                                   high_parity_pin_oe_o,
  output logic                                   store_ready_o
);

  localparam int AW = sram_cycle_pkg::ADDR_W;
  localparam int BW = sram_cycle_pkg::BURST_W;
  localparam int NL = sram_cycle_pkg::LANES;

  sram_cycle_pkg::bus_state_type                  state_ff;
  sram_cycle_pkg::bus_state_type                  nxt_state;
  logic [AW-1:0]                                  base_ff;
  logic [AW-1:0]                                  nxt_base;
  logic [BW-1:0]                                  count_ff;
  logic [BW-1:0]                                  nxt_count;
  logic                                           drive_ff;
  logic                                           nxt_drive;
  sram_cycle_pkg::lane_type [NL-1:0]              rdata_ff;
  sram_cycle_pkg::lane_type [NL-1:0]              nxt_rdata;
  logic                                           store_ready_ff;
  logic [sram_cycle_pkg::PIN_COUNT-1:0]           pin_ff;
  logic [sram_cycle_pkg::PIN_COUNT-1:0]           nxt_pin;
  logic [sram_cycle_pkg::PIN_COUNT-1:0]           chain_ff [sram_cycle_pkg::SYNC_STAGES];
  sram_cycle_pkg::op_type                         op;
  logic [AW-1:0]                                  acc_addr;
  logic [AW-1:0]                                  cur_addr;
  logic [AW-1:0]                                  step_addr;
  logic                                           selected;
  logic                                           write_n;
  logic [NL-1:0]                                  lane_en;
  logic                                           snooze;
  logic                                           interleave;
  sram_cycle_pkg::store_type                      push_data;
  sram_cycle_pkg::store_type                      head;
  logic [sram_cycle_pkg::STORE_W-1:0]             head_bits;
  logic                                           head_valid;
  logic                                           fifo_in_ready;
  logic [sram_cycle_pkg::LANE_DATA_W:0]           lane_mem [NL][2**AW];

  // ==========================================================================
  // Pin synchronisers for the asynchronous snooze and static order pins
  // ==========================================================================
  // A level is taken over only once the second and third stages agree.
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      for (int s = 0; s < sram_cycle_pkg::SYNC_STAGES; s++) begin
        chain_ff[s] <= sram_cycle_pkg::PIN_RESET;
      end
      pin_ff <= sram_cycle_pkg::PIN_RESET;
    end else begin
      chain_ff[0] <= {burst_order_i, snooze_request_i};
      chain_ff[1] <= chain_ff[0];
      chain_ff[2] <= chain_ff[1];
      pin_ff      <= nxt_pin;
    end
  end

  generate
    for (genvar p = 0; p < sram_cycle_pkg::PIN_COUNT; p++) begin : g_pin
      assign nxt_pin[p] = (chain_ff[1][p] == chain_ff[2][p]) ? chain_ff[2][p] : pin_ff[p];
    end
  endgenerate

  assign snooze     = pin_ff[sram_cycle_pkg::PIN_SNOOZE];
  assign interleave = pin_ff[sram_cycle_pkg::PIN_ORDER];

  // ==========================================================================
  // Burst address generation
  // ==========================================================================
  function automatic logic [AW-1:0] burst_addr(input logic [AW-1:0] base, input logic [BW-1:0] cnt,
                                               input logic order);
    logic [BW-1:0] low;
    low = order ? (base[BW-1:0] ^ cnt) : BW'(base[BW-1:0] + cnt);  // [RQ16] [RQ18]
    return {base[AW-1:BW], low};                                   // [RQ17]
  endfunction : burst_addr

  assign cur_addr  = burst_addr(base_ff, count_ff, interleave);
  assign step_addr = burst_addr(base_ff, BW'(count_ff + sram_cycle_pkg::COUNT_STEP), interleave);

  // ==========================================================================
  // Cycle decode
  // ==========================================================================
  always_comb begin
    selected = !primary_select_n_i && !second_select_n_i && third_select_high_i;
    write_n  = !(!all_bytes_store_n_i || (!byte_write_gate_n_i && (!low_byte_store_n_i || !high_byte_store_n_i)));  // [RQ9]
    if (!all_bytes_store_n_i) begin
      lane_en = sram_cycle_pkg::ALL_LANES;                                                // [RQ9]
    end else begin
      lane_en = {!byte_write_gate_n_i && !high_byte_store_n_i, !byte_write_gate_n_i && !low_byte_store_n_i};  // [RQ10]
    end
  end

  always_comb begin
    nxt_state = state_ff;
    nxt_base  = base_ff;
    nxt_count = count_ff;
    op        = sram_cycle_pkg::OP_IDLE;
    acc_addr  = cur_addr;
    if (snooze) begin
      nxt_state = sram_cycle_pkg::DESELECTED;
    end else if (!primary_select_n_i && !processor_addr_strobe_n_i) begin
      if (selected) begin
        nxt_state = sram_cycle_pkg::SELECTED;                                             // [RQ2] [RQ14]
        nxt_base  = address_i;
        nxt_count = sram_cycle_pkg::COUNT_RESET;
        acc_addr  = address_i;
        op        = sram_cycle_pkg::OP_READ;
      end else begin
        nxt_state = sram_cycle_pkg::DESELECTED;                                           // [RQ1]
      end
    end else if (!controller_addr_strobe_n_i) begin
      if (selected) begin
        nxt_state = sram_cycle_pkg::SELECTED;
        nxt_base  = address_i;
        nxt_count = sram_cycle_pkg::COUNT_RESET;
        acc_addr  = address_i;
        op        = write_n ? sram_cycle_pkg::OP_READ : sram_cycle_pkg::OP_WRITE;         // [RQ3]
      end else begin
        nxt_state = sram_cycle_pkg::DESELECTED;                                           // [RQ1]
      end
    end else begin
      case (state_ff)
        sram_cycle_pkg::SELECTED: begin
          if (!burst_step_n_i) begin
            nxt_count = BW'(count_ff + sram_cycle_pkg::COUNT_STEP);                       // [RQ4] [RQ5] [RQ18]
            acc_addr  = step_addr;
          end
          // A held advance keeps the counter: a wait cycle on the current word.
          op = write_n ? sram_cycle_pkg::OP_READ : sram_cycle_pkg::OP_WRITE;              // [RQ6] [RQ7] [RQ8] [RQ15]
        end
        default: begin
          op = sram_cycle_pkg::OP_IDLE;
        end
      endcase
    end
  end

  // ==========================================================================
  // Write queue and cell array
  // ==========================================================================
  always_comb begin
    push_data.addr    = acc_addr;
    push_data.lanes   = {{high_parity_pin_i, dq_i[15:8]}, {low_parity_pin_i, dq_i[7:0]}};  // [RQ10]
    push_data.lane_en = (op == sram_cycle_pkg::OP_WRITE) ? lane_en : sram_cycle_pkg::NO_LANES;
  end

  // The array stops draining while snoozing, so queued writes wait in the queue until snooze ends.
  store_fifo #(
    .WIDTH (sram_cycle_pkg::STORE_W),
    .DEPTH (sram_cycle_pkg::FIFO_DEPTH)
  ) u_store_fifo (
    .core_clk_i  (core_clk_i),
    .resetn_i    (resetn_i),
    .in_valid_i  (op == sram_cycle_pkg::OP_WRITE),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (push_data),
    .out_valid_o (head_valid),
    .out_ready_i (!snooze),
    .out_data_o  (head_bits)
  );

  assign head = sram_cycle_pkg::store_type'(head_bits);

  // The word being retired this edge is forwarded so a read right after a write sees it.
  generate
    for (genvar l = 0; l < NL; l++) begin : g_lane
      always_ff @(posedge core_clk_i) begin
        if (head_valid && !snooze && head.lane_en[l]) begin
          lane_mem[l][head.addr] <= head.lanes[l];                                         // [RQ10]
        end
      end
      assign nxt_rdata[l] = (head_valid && !snooze && head.lane_en[l] && head.addr == acc_addr) ?
                            head.lanes[l] : lane_mem[l][acc_addr];
    end
  endgenerate

  // ==========================================================================
  // Output registers
  // ==========================================================================
  assign nxt_drive = (op == sram_cycle_pkg::OP_READ);                                      // [RQ2] [RQ4] [RQ6]

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state_ff       <= sram_cycle_pkg::DESELECTED;
      base_ff        <= sram_cycle_pkg::ADDR_RESET;
      count_ff       <= sram_cycle_pkg::COUNT_RESET;
      drive_ff       <= 1'b0;                                                              // [RQ13]
      rdata_ff       <= '0;
      store_ready_ff <= 1'b0;
    end else begin
      state_ff       <= nxt_state;                                                         // [RQ11]
      base_ff        <= nxt_base;
      count_ff       <= nxt_count;
      drive_ff       <= nxt_drive;
      rdata_ff       <= nxt_rdata;
      store_ready_ff <= fifo_in_ready;
    end
  end

  // Output enable bypasses the clock and gates the drivers directly.
  assign dq_oe_o              = {16{drive_ff && !output_enable_n_i}};                       // [RQ11]
  assign low_parity_pin_oe_o  = drive_ff && !output_enable_n_i;
  assign high_parity_pin_oe_o = drive_ff && !output_enable_n_i;
  assign dq_o                 = {rdata_ff[1].data, rdata_ff[0].data};
  assign low_parity_pin_o     = rdata_ff[0].par;
  assign high_parity_pin_o    = rdata_ff[1].par;
  assign store_ready_o        = store_ready_ff;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  deselect_hiz_a : assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // [RQ1]
    (!snooze && !controller_addr_strobe_n_i && primary_select_n_i) |=> !drive_ff && !dq_oe_o[0])
    else $error("deselect cycle left the drivers on");

  proc_read_a : assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // [RQ14]
    (!snooze && !processor_addr_strobe_n_i && selected) |=>
      drive_ff && count_ff == sram_cycle_pkg::COUNT_RESET && base_ff == $past(address_i))
    else $error("processor strobe did not start a read");

  ctrl_write_a : assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // [RQ3]
    (!snooze && processor_addr_strobe_n_i && !controller_addr_strobe_n_i && selected && !write_n) |=>
      !drive_ff && head_valid && base_ff == $past(address_i))
    else $error("controller write did not capture data");

  burst_read_a : assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // [RQ4]
    (!snooze && state_ff == sram_cycle_pkg::SELECTED && processor_addr_strobe_n_i && controller_addr_strobe_n_i
      && !burst_step_n_i && write_n) |=>
      drive_ff && count_ff == BW'($past(count_ff) + sram_cycle_pkg::COUNT_STEP) && base_ff == $past(base_ff))
    else $error("continued read did not step the counter");

  burst_write_a : assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // [RQ5]
    (!snooze && state_ff == sram_cycle_pkg::SELECTED && processor_addr_strobe_n_i && controller_addr_strobe_n_i
      && !burst_step_n_i && !write_n) |=>
      !drive_ff && count_ff == BW'($past(count_ff) + sram_cycle_pkg::COUNT_STEP))
    else $error("continued write did not step the counter");

  wait_hold_a : assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // [RQ8]
    (!snooze && state_ff == sram_cycle_pkg::SELECTED && processor_addr_strobe_n_i && controller_addr_strobe_n_i
      && burst_step_n_i) |=> $stable(count_ff) && $stable(base_ff) && drive_ff == $past(write_n))
    else $error("wait cycle moved the burst address");

  write_mute_a : assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // [RQ7]
    (op == sram_cycle_pkg::OP_WRITE) |=> !dq_oe_o[15] && !low_parity_pin_oe_o && !high_parity_pin_oe_o)
    else $error("drivers on after a write cycle");

  all_lanes_a : assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // [RQ9]
    (op == sram_cycle_pkg::OP_WRITE && !all_bytes_store_n_i && fifo_in_ready && !head_valid) |=>
      head.lane_en == sram_cycle_pkg::ALL_LANES)
    else $error("global write did not enable both lanes");

  low_lane_a : assert property (@(posedge core_clk_i) disable iff (!resetn_i)  // [RQ10]
    (op == sram_cycle_pkg::OP_WRITE && all_bytes_store_n_i && high_byte_store_n_i && fifo_in_ready
      && !head_valid) |=> head.lane_en == 2'h1 && head.lanes[0].par == $past(low_parity_pin_i))
    else $error("low byte write reached the wrong lane");

  powerup_hiz_a : assert property (@(posedge core_clk_i)  // [RQ13]
    !resetn_i |-> !dq_oe_o[0] && !low_parity_pin_oe_o && !high_parity_pin_oe_o)
    else $error("drivers on during reset");

endmodule : burst_sram_cycle_control

// ### core/sram_cycle_pkg.sv
// Shared widths, reset values and carrier types of the burst SRAM cycle control.
package sram_cycle_pkg;

  // ==========================================================================
  // Widths and depths
  // ==========================================================================
  localparam int ADDR_W      = 17;
  localparam int LANES       = 2;
  localparam int LANE_DATA_W = 8;
  localparam int BURST_W     = 2;
  localparam int FIFO_DEPTH  = 4;
  localparam int SYNC_STAGES = 3;
  localparam int PIN_COUNT   = 2;

  // ==========================================================================
  // Reset values and counts
  // ==========================================================================
  localparam logic [ADDR_W-1:0]    ADDR_RESET  = 17'h00000;
  localparam logic [BURST_W-1:0]   COUNT_RESET = 2'h0;
  localparam logic [BURST_W-1:0]   COUNT_STEP  = 2'h1;
  localparam logic [LANES-1:0]     ALL_LANES   = 2'h3;
  localparam logic [LANES-1:0]     NO_LANES    = 2'h0;
  // Bit 0 is the snooze pin (idle low), bit 1 the burst order pin (pulled high).
  localparam int                   PIN_SNOOZE  = 0;
  localparam int                   PIN_ORDER   = 1;
  localparam logic [PIN_COUNT-1:0] PIN_RESET   = 2'h2;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic                   par;
    logic [LANE_DATA_W-1:0] data;
  } lane_type;

  typedef struct packed {
    logic [ADDR_W-1:0]       addr;
    lane_type [LANES-1:0]    lanes;
    logic [LANES-1:0]        lane_en;
  } store_type;

  localparam int STORE_W = $bits(store_type);

  typedef enum logic {
    DESELECTED,
    SELECTED
  } bus_state_type;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_READ,
    OP_WRITE
  } op_type;

endpackage : sram_cycle_pkg

// ### core/store_fifo.sv
// Small synchronous FIFO that queues array writes between the bus and the cell array.
`timescale 1ns/1ns
module store_fifo #(
  parameter int WIDTH = 44,
  parameter int DEPTH = 4
) (
  input  wire logic             core_clk_i,
  input  wire logic             resetn_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic [WIDTH-1:0]      out_data_o
);

  localparam int PTR_W = $clog2(DEPTH);

  logic [WIDTH-1:0] slot_ff [DEPTH];
  logic [PTR_W:0]   wr_ptr_ff;
  logic [PTR_W:0]   rd_ptr_ff;
  logic [PTR_W:0]   nxt_wr_ptr;
  logic [PTR_W:0]   nxt_rd_ptr;
  logic             push;
  logic             pop;
  logic             full;
  logic             empty;

  // ==========================================================================
  // Pointer logic
  // ==========================================================================
  always_comb begin
    empty      = (wr_ptr_ff == rd_ptr_ff);
    full       = (wr_ptr_ff[PTR_W] != rd_ptr_ff[PTR_W]) && (wr_ptr_ff[PTR_W-1:0] == rd_ptr_ff[PTR_W-1:0]);
    push       = in_valid_i && !full;
    pop        = out_ready_i && !empty;
    nxt_wr_ptr = push ? wr_ptr_ff + 1'b1 : wr_ptr_ff;
    nxt_rd_ptr = pop ? rd_ptr_ff + 1'b1 : rd_ptr_ff;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
    end
  end

  // Storage slots hold no control state and need no reset.
  always_ff @(posedge core_clk_i) begin
    if (push) begin
      slot_ff[wr_ptr_ff[PTR_W-1:0]] <= in_data_i;
    end
  end

  assign in_ready_o  = !full;
  assign out_valid_o = !empty;
  assign out_data_o  = slot_ff[rd_ptr_ff[PTR_W-1:0]];

endmodule : store_fifo

// ### testbench/bus_partner_model.sv
// Bus-side controller model that resolves the shared data wires and the output enable.
`timescale 1ns/1ns
module bus_partner_model (
  input  wire logic        core_clk_i,
  input  wire logic [17:0] dev_q_i,
  input  wire logic [17:0] dev_oe_i,
  input  wire logic [17:0] host_d_i,
  input  wire logic        host_en_i,
  input  wire logic        oe_req_n_i,
  output logic [17:0]      wire_o,
  output logic             oe_n_o
);
  logic [17:0] last_ff;
  // Output enable is forced high for the whole cycle in which write data is driven.
  assign oe_n_o = oe_req_n_i | host_en_i;
  // A wire nobody drives shows the inverse of its last level, so stale data never passes.
  always_comb begin
    for (int i = 0; i < 18; i++) begin
      wire_o[i] = dev_oe_i[i] ? dev_q_i[i] : (host_en_i ? host_d_i[i] : ~last_ff[i]);
    end
  end
  always_ff @(posedge core_clk_i) begin
    last_ff <= wire_o;
  end
endmodule : bus_partner_model

// ### testbench/sync_burst_sram_cycle_control_tb_top.sv
// Self-checking bench of the burst SRAM cycle control with a reference memory model.
`timescale 1ns/1ns
module sync_burst_sram_cycle_control_tb_top;
  logic        clk, rst_n, pc_n, s2_n, s3, ps_n, cs_n, adv_n, gate_n, gw_n, lo_n, hi_n, ord;
  logic        host_en, oe_req_n, oe_n, lpo, lpe, hpo, hpe, rdy, sel_st, pv, cord;
  logic [16:0] addr, base, a;
  logic [1:0]  cnt;
  logic [15:0] dq_o, dq_oe;
  logic [17:0] host_d, bus, dev_q, dev_oe, pexp;
  logic [17:0] mem [int];
  logic [31:0] seed;
  int          err_count, n_tests, cycles;
  int          dk [4] = '{2, 1, 1, 2};
  logic [2:0]  ds [4] = '{3'h5, 3'h3, 3'h0, 3'h2};
  assign dev_q  = {hpo, lpo, dq_o};
  assign dev_oe = {hpe, lpe, dq_oe};

  burst_sram_cycle_control DUT (.core_clk_i(clk), .resetn_i(rst_n), .address_i(addr),
    .primary_select_n_i(pc_n), .second_select_n_i(s2_n), .third_select_high_i(s3),
    .processor_addr_strobe_n_i(ps_n), .controller_addr_strobe_n_i(cs_n), .burst_step_n_i(adv_n),
    .byte_write_gate_n_i(gate_n), .all_bytes_store_n_i(gw_n), .low_byte_store_n_i(lo_n),
    .high_byte_store_n_i(hi_n), .output_enable_n_i(oe_n), .burst_order_i(ord), .snooze_request_i(1'b0),
    .dq_i(bus[15:0]), .dq_o(dq_o), .dq_oe_o(dq_oe), .low_parity_pin_i(bus[16]), .low_parity_pin_o(lpo),
    .low_parity_pin_oe_o(lpe), .high_parity_pin_i(bus[17]), .high_parity_pin_o(hpo),
    .high_parity_pin_oe_o(hpe), .store_ready_o(rdy));
  bus_partner_model partner (.core_clk_i(clk), .dev_q_i(dev_q), .dev_oe_i(dev_oe), .host_d_i(host_d),
    .host_en_i(host_en), .oe_req_n_i(oe_req_n), .wire_o(bus), .oe_n_o(oe_n));

  // ==========================================================================
  // Helpers
  // ==========================================================================
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  function automatic logic [16:0] exp_addr(input logic [16:0] b, input logic [1:0] c, input logic o);
    return {b[16:2], o ? (b[1:0] ^ c) : (b[1:0] + c)};
  endfunction : exp_addr
  function automatic logic [17:0] lane_merge(input logic [17:0] m, input logic [17:0] d, input logic [1:0] ln);
    if (ln[0]) {m[16], m[7:0]} = {d[16], d[7:0]};
    if (ln[1]) {m[17], m[15:8]} = {d[17], d[15:8]};
    return m;
  endfunction : lane_merge
  task automatic chk(input string name, input logic [17:0] seen, input logic [17:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // Kind 1 processor strobe, 2 controller strobe, 3 continue, 4 suspend; sel is the raw select pins.
  task automatic step(input int k, input logic [2:0] sel, input logic [16:0] ad, input logic [1:0] ln,
                      input logic [17:0] d);
    logic [31:0] r;
    logic        wr;
    logic [16:0] ea;
    r  = rnd();
    wr = (ln != 2'h0);
    @(posedge clk);
    {pc_n, s2_n, s3} <= sel;
    ps_n     <= (k != 1);
    cs_n     <= (k != 2);
    adv_n    <= (k != 3);
    gw_n     <= !(wr && ln == 2'h3 && r[0]);
    gate_n   <= wr ? (ln == 2'h3 && r[0] && r[1]) : r[2];
    lo_n     <= wr ? ~ln[0] : (r[2] ? r[3] : 1'b1);
    hi_n     <= wr ? ~ln[1] : (r[2] ? r[4] : 1'b1);
    addr     <= ad;
    host_d   <= d;
    host_en  <= wr && k != 1;
    oe_req_n <= r[5] & r[6];
    #1;
    chk("drive", dev_oe, {18{pv & ~(oe_req_n | host_en)}});
    if (pv) chk("data", dev_q, pexp);
    chk("ready", {17'h00000, rdy}, 18'h00001);
    if (k == 1 || k == 2) begin
      sel_st = (sel == 3'h1);
      base   = ad;
      cnt    = 2'h0;
    end else if (sel_st && k == 3) cnt = cnt + 2'h1;
    ea = exp_addr(base, cnt, cord);
    pv = sel_st && (k == 1 || !wr);
    if (sel_st && wr && k != 1) mem[ea] = lane_merge(mem.exists(ea) ? mem[ea] : 18'h00000, d, ln);
    if (pv) pexp = mem[ea];
  endtask : step

  // ==========================================================================
  // Clock, timeout and main sequence
  // ==========================================================================
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    {pc_n, s2_n, s3, ps_n, cs_n, adv_n, gate_n, gw_n, lo_n, hi_n} = 10'h37F;
    {rst_n, ord, host_en, oe_req_n, sel_st, pv, cord} = 7'h08;
    {addr, base, cnt, host_d, pexp} = '0;
    seed = 32'h0000DF80;
    @(posedge clk);
    #1 chk("reset drive", dev_oe, 18'h00000);
    chk("reset ready", {17'h00000, rdy}, 18'h00000);
    @(posedge clk) rst_n <= 1'b1;
    for (int p = 0; p < 2; p++) begin
      ord <= p[0];
      repeat (6) step(4, 3'h1, 17'h00000, 2'h0, 18'h00000);
      cord = p[0];
      for (int i = 0; i < 8; i++) begin
        a = 17'(rnd());
        step(2, 3'h1, a, 2'h3, 18'(rnd()));
        repeat (3) step(3, 3'h1, 17'h00000, 2'h3, 18'(rnd()));
        step(4, 3'h1, 17'h00000, 2'h0, 18'h00000);
        step(1, 3'h1, a, 2'(rnd() % 3 + 1), 18'(rnd()));
        step(4, 3'h1, 17'h00000, (i == 0) ? 2'h1 : 2'(rnd() % 3 + 1), 18'(rnd()));
        step(4, 3'h1, 17'h00000, 2'h0, 18'h00000);
        repeat (4) step(3, 3'h1, 17'h00000, 2'h0, 18'h00000);
        step(dk[i % 4], ds[i % 4], a, 2'h0, 18'h00000);
        step(3, 3'h1, 17'h00000, 2'h0, 18'h00000);
      end
    end
    step(4, 3'h1, 17'h00000, 2'h0, 18'h00000);
    report_and_stop();
  end
endmodule : sync_burst_sram_cycle_control_tb_top
